// File: ccs_pkg.sv
package ccs_pkg;
  localparam int CCS_ADR_W = 4;
  localparam int CCS_DAT_W = 32;
  localparam int CCS_SEL_W = 4;
  localparam int CCS_CNT_W = 16;
  localparam logic [3:0] CCS_OFS_CLK_SEL = 4'h0;
  localparam logic [3:0] CCS_OFS_MODE_CFG = 4'h4;
  localparam logic [3:0] CCS_OFS_OSC_CTRL = 4'h8;
  localparam logic [3:0] CCS_OFS_STATUS = 4'hc;
  localparam logic [3:0] CCS_SEL_BYTE0 = 4'h1;
  localparam int CCS_DIV_LSB = 0;
  localparam int CCS_DIV_W = 3;
  localparam int CCS_MSEL_BIT = 4;
  localparam int CCS_MSTAT_BIT = 5;
  localparam int CCS_CSEL_BIT = 6;
  localparam int CCS_CSTAT_BIT = 7;
  localparam int CCS_CFG_EXT_BIT = 0;
  localparam int CCS_CFG_HSPIN_BIT = 1;
  localparam int CCS_CFG_SUBPIN_BIT = 2;
  localparam int CCS_OSC_HSSTOP_BIT = 0;
  localparam int CCS_OSC_SUBSTOP_BIT = 1;
  localparam int CCS_OSC_INTSTOP_BIT = 2;
  localparam int CCS_ST_HSRDY_BIT = 0;
  localparam int CCS_ST_SUBRDY_BIT = 1;
  localparam int CCS_ST_BUSY_BIT = 2;
  localparam int CCS_ST_REFUSED_BIT = 3;
  localparam int CCS_ST_CFGDONE_BIT = 4;
  localparam logic [2:0] CCS_DIV_RST = 3'h0;
  localparam logic CCS_HSSTOP_RST = 1'b1;
  localparam logic CCS_SUBSTOP_RST = 1'b1;
  localparam logic CCS_INTSTOP_RST = 1'b0;
  localparam logic [CCS_CNT_W-1:0] CCS_CNT_ONE = 16'h0001;
  localparam int CCS_F_IH_KHZ = 8000;
  localparam int CCS_F_MX_KHZ = 10000;
  localparam int CCS_F_SUB_KHZ = 32;
  typedef enum logic [1:0] {
    ccs_idle, ccs_wait, ccs_gate, ccs_switch
  } ccs_state_t;
endpackage

// File: ccs_clock_switch.sv
`timescale 1ns/1ps
module ccs_clock_switch #(
  parameter int F_IH_KHZ = ccs_pkg::CCS_F_IH_KHZ,
  parameter int F_MX_KHZ = ccs_pkg::CCS_F_MX_KHZ,
  parameter int F_SUB_KHZ = ccs_pkg::CCS_F_SUB_KHZ
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ccs_pkg::CCS_ADR_W-1:0] wb_adr_i,
  input wire logic [ccs_pkg::CCS_SEL_W-1:0] wb_sel_i,
  input wire logic [ccs_pkg::CCS_DAT_W-1:0] wb_dat_i,
  output logic [ccs_pkg::CCS_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic hs_ready_pin,
  input wire logic sub_ready_pin,
  output logic hs_osc_en,
  output logic hs_ext_en,
  output logic sub_osc_en,
  output logic int_osc_en,
  output logic main_hs_sel,
  output logic [ccs_pkg::CCS_DIV_W-1:0] main_div,
  output logic cpu_sub_sel,
  output logic periph_sub_sel,
  output logic clk_gate_off,
  output logic switch_busy
);
  import ccs_pkg::*;

  ccs_state_t state;
  logic [CCS_CNT_W-1:0] cnt;
  logic [CCS_DIV_W-1:0] div_reg;
  logic msel_reg, csel_reg, mstat, cstat;
  logic cfg_ext, cfg_hspin, cfg_subpin, cfg_done;
  logic hs_stop, sub_stop, int_stop, refused;
  logic [2:0] hs_sync, sub_sync;
  logic hs_rdy, sub_rdy;
  logic wb_req, wr, rd;
  logic wr_sel, wr_cfg, wr_osc, wr_st;
  logic [CCS_DIV_W-1:0] new_div;
  logic new_m, new_c, sel_ok, sel_chg;
  logic hs_usable;
  logic next_hs_stop, next_sub_stop, next_int_stop, osc_bad;
  logic [7:0] rd_byte;

  function automatic int cdiv(input int n, input int d);
    return (n + d - 1) / d;
  endfunction

  // Fractions rounded up: the conservative whole-cycle bound
  function automatic logic [CCS_CNT_W-1:0] switch_cycles(
    input logic [CCS_DIV_W-1:0] od, input logic [CCS_DIV_W-1:0] nd,
    input logic om, input logic nm, input logic oc, input logic nc);
    int fm, n, a, b;
    a = int'(od);
    b = int'(nd);
    fm = (om ? F_MX_KHZ : F_IH_KHZ) >> a;
    if (fm < 1)
      fm = 1;
    if (oc != nc) begin
      if (!oc)
        n = (fm < F_SUB_KHZ) ? 2 + cdiv(fm, F_SUB_KHZ)
                             : 1 + cdiv(2 * fm, F_SUB_KHZ);
      else
        n = (fm < F_SUB_KHZ) ? 1 + cdiv(2 * F_SUB_KHZ, fm)
                             : 2 + cdiv(F_SUB_KHZ, fm);
    end else if (om != nm) begin
      if (!om)
        n = (F_MX_KHZ > F_IH_KHZ) ? 1 + cdiv(F_MX_KHZ, F_IH_KHZ)
                                  : cdiv(2 * F_IH_KHZ, F_MX_KHZ);
      else
        n = (F_MX_KHZ > F_IH_KHZ) ? cdiv(2 * F_MX_KHZ, F_IH_KHZ)
                                  : 1 + cdiv(F_MX_KHZ, F_IH_KHZ);
    end else begin
      n = 1 + ((b > a) ? (1 << (b - a)) : 1);
    end
    return CCS_CNT_W'(n);
  endfunction

  // Pin inputs: a change counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hs_sync <= 3'h0;
      sub_sync <= 3'h0;
      hs_rdy <= 1'b0;
      sub_rdy <= 1'b0;
    end else if (clk_en) begin
      hs_sync <= {hs_sync[1:0], hs_ready_pin};
      sub_sync <= {sub_sync[1:0], sub_ready_pin};
      if (hs_sync[1] == hs_sync[2])
        hs_rdy <= hs_sync[2];
      if (sub_sync[1] == sub_sync[2])
        sub_rdy <= sub_sync[2];
    end
  end

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_req & wb_we_i & wb_sel_i[0];
  assign rd = wb_req & ~wb_we_i;
  assign wr_sel = wr && (wb_adr_i == CCS_OFS_CLK_SEL);
  assign wr_cfg = wr && (wb_adr_i == CCS_OFS_MODE_CFG);
  assign wr_osc = wr && (wb_adr_i == CCS_OFS_OSC_CTRL);
  assign wr_st = wr && (wb_adr_i == CCS_OFS_STATUS);
  assign new_div = wb_dat_i[CCS_DIV_LSB +: CCS_DIV_W];
  assign new_m = wb_dat_i[CCS_MSEL_BIT];
  assign new_c = wb_dat_i[CCS_CSEL_BIT];
  // Crystal needs stabilization; external input does not
  assign hs_usable = cfg_hspin & ~hs_stop & (cfg_ext | hs_rdy);

  always_comb begin
    sel_ok = (state == ccs_idle);
    if (new_m && !mstat)
      sel_ok = sel_ok & hs_usable;
    if (!new_m && mstat)
      sel_ok = sel_ok & ~int_stop;
    if (new_c && !cstat)
      sel_ok = sel_ok & cfg_subpin & ~sub_stop & sub_rdy;
    // Main must already sit on a live source before leaving subsystem
    if (!new_c && cstat)
      sel_ok = sel_ok & (new_m == mstat) &
               (mstat ? hs_usable : ~int_stop);
    sel_chg = (new_div != div_reg) | (new_m != msel_reg) |
              (new_c != csel_reg);
  end

  always_comb begin
    next_hs_stop = wb_dat_i[CCS_OSC_HSSTOP_BIT];
    next_sub_stop = wb_dat_i[CCS_OSC_SUBSTOP_BIT];
    next_int_stop = wb_dat_i[CCS_OSC_INTSTOP_BIT];
    osc_bad = 1'b0;
    // A source in use or mid-switch keeps running
    if (next_int_stop && !int_stop &&
        !((mstat | cstat) && state == ccs_idle)) begin
      next_int_stop = 1'b0;
      osc_bad = 1'b1;
    end
    if (next_hs_stop && !hs_stop &&
        !((!mstat | cstat) && state == ccs_idle)) begin
      next_hs_stop = 1'b0;
      osc_bad = 1'b1;
    end
    if (next_sub_stop && !sub_stop &&
        !(!cstat && state == ccs_idle)) begin
      next_sub_stop = 1'b0;
      osc_bad = 1'b1;
    end
  end

  // Select register: refused writes leave every field unchanged
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_reg <= CCS_DIV_RST;
      msel_reg <= 1'b0;
      csel_reg <= 1'b0;
    end else if (clk_en && wr_sel && sel_ok) begin
      div_reg <= new_div;
      msel_reg <= new_m;
      csel_reg <= new_c;
    end
  end

  // Write-once byte access; crystal/external fixed until reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_ext <= 1'b0;
      cfg_hspin <= 1'b0;
      cfg_subpin <= 1'b0;
      cfg_done <= 1'b0;
    end else if (clk_en && wr_cfg && !cfg_done &&
                 wb_sel_i == CCS_SEL_BYTE0) begin
      cfg_ext <= wb_dat_i[CCS_CFG_EXT_BIT];
      cfg_hspin <= wb_dat_i[CCS_CFG_HSPIN_BIT];
      cfg_subpin <= wb_dat_i[CCS_CFG_SUBPIN_BIT];
      cfg_done <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hs_stop <= CCS_HSSTOP_RST;
      sub_stop <= CCS_SUBSTOP_RST;
      int_stop <= CCS_INTSTOP_RST;
    end else if (clk_en && wr_osc) begin
      hs_stop <= next_hs_stop;
      sub_stop <= next_sub_stop;
      int_stop <= next_int_stop;
    end
  end

  // Sticky refusal flag; a new refusal beats a clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst)
      refused <= 1'b0;
    else if (clk_en) begin
      if ((wr_sel && !sel_ok) || (wr_osc && osc_bad) ||
          (wr_cfg && (cfg_done || wb_sel_i != CCS_SEL_BYTE0)))
        refused <= 1'b1;
      else if (wr_st && wb_dat_i[CCS_ST_REFUSED_BIT])
        refused <= 1'b0;
    end
  end

  // Old selection holds for the bound, then one gated cycle,
  // then new selection; status trails the selects by a cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ccs_idle;
      cnt <= '0;
    end else if (clk_en) begin
      case (state)
        ccs_idle: begin
          if (wr_sel && sel_ok && sel_chg) begin
            state <= ccs_wait;
            cnt <= switch_cycles(div_reg, new_div, msel_reg, new_m,
                                 csel_reg, new_c);
          end
        end
        ccs_wait: begin
          cnt <= cnt - CCS_CNT_ONE;
          if (cnt <= CCS_CNT_ONE)
            state <= ccs_gate;
        end
        ccs_gate: state <= ccs_switch;
        ccs_switch: state <= ccs_idle;
        default: state <= ccs_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      main_hs_sel <= 1'b0;
      main_div <= CCS_DIV_RST;
      cpu_sub_sel <= 1'b0;
      periph_sub_sel <= 1'b0;
      clk_gate_off <= 1'b0;
      mstat <= 1'b0;
      cstat <= 1'b0;
    end else if (clk_en) begin
      clk_gate_off <= (state == ccs_wait) && (cnt <= CCS_CNT_ONE);
      if (state == ccs_gate) begin
        main_hs_sel <= msel_reg;
        main_div <= div_reg;
        cpu_sub_sel <= csel_reg;
        periph_sub_sel <= csel_reg;
      end
      if (state == ccs_switch) begin
        mstat <= main_hs_sel;
        cstat <= cpu_sub_sel;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      hs_osc_en <= 1'b0;
      hs_ext_en <= 1'b0;
      sub_osc_en <= 1'b0;
      int_osc_en <= 1'b0;
      switch_busy <= 1'b0;
    end else if (clk_en) begin
      hs_osc_en <= cfg_hspin & ~cfg_ext & ~hs_stop;
      hs_ext_en <= cfg_hspin & cfg_ext & ~hs_stop;
      sub_osc_en <= cfg_subpin & ~sub_stop;
      int_osc_en <= ~int_stop;
      switch_busy <= (state != ccs_idle) || (wr_sel && sel_ok && sel_chg);
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (wb_adr_i)
      CCS_OFS_CLK_SEL: begin
        rd_byte[CCS_DIV_LSB +: CCS_DIV_W] = div_reg;
        rd_byte[CCS_MSEL_BIT] = msel_reg;
        rd_byte[CCS_MSTAT_BIT] = mstat;
        rd_byte[CCS_CSEL_BIT] = csel_reg;
        rd_byte[CCS_CSTAT_BIT] = cstat;
      end
      CCS_OFS_MODE_CFG: begin
        rd_byte[CCS_CFG_EXT_BIT] = cfg_ext;
        rd_byte[CCS_CFG_HSPIN_BIT] = cfg_hspin;
        rd_byte[CCS_CFG_SUBPIN_BIT] = cfg_subpin;
      end
      CCS_OFS_OSC_CTRL: begin
        rd_byte[CCS_OSC_HSSTOP_BIT] = hs_stop;
        rd_byte[CCS_OSC_SUBSTOP_BIT] = sub_stop;
        rd_byte[CCS_OSC_INTSTOP_BIT] = int_stop;
      end
      CCS_OFS_STATUS: begin
        rd_byte[CCS_ST_HSRDY_BIT] = hs_rdy;
        rd_byte[CCS_ST_SUBRDY_BIT] = sub_rdy;
        rd_byte[CCS_ST_BUSY_BIT] = (state != ccs_idle);
        rd_byte[CCS_ST_REFUSED_BIT] = refused;
        rd_byte[CCS_ST_CFGDONE_BIT] = cfg_done;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // Every access, mapped or not, is acked one cycle after request
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (clk_en) begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd ? {24'h000000, rd_byte} : '0;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst || !clk_en);

  sequence gate_cycle;
    clk_gate_off ##1 !clk_gate_off;
  endsequence

  sequence status_settles;
    (cstat == cpu_sub_sel) && (mstat == main_hs_sel);
  endsequence

  xtal_select_guard_a: assert property (
    $rose(msel_reg) && !cfg_ext |-> $past(hs_rdy && !hs_stop && cfg_hspin))
    else $error("crystal selected before it was stable");
  ext_select_guard_a: assert property (
    $rose(msel_reg) && cfg_ext |-> $past(!hs_stop && cfg_hspin))
    else $error("external input selected while disabled");
  sub_select_guard_a: assert property (
    $rose(csel_reg) |-> $past(sub_rdy && !sub_stop && cfg_subpin))
    else $error("subsystem clock selected before it was ready");
  int_return_guard_a: assert property (
    $fell(msel_reg) |-> $past(!int_stop))
    else $error("internal oscillator selected while stopped");
  cfg_frozen_a: assert property (
    $past(cfg_done) |-> $stable(cfg_ext) && $stable(cfg_hspin))
    else $error("mode configuration changed after first write");
  old_clock_hold_a: assert property (
    state == ccs_wait && cnt == CCS_CNT_ONE
      |=> state == ccs_gate ##1 cpu_sub_sel == csel_reg)
    else $error("switch did not follow end of old-clock wait");
  cpu_status_a: assert property (
    state == ccs_idle |-> cstat == cpu_sub_sel)
    else $error("CPU status disagrees with applied select");
  periph_follow_a: assert property (
    periph_sub_sel == cpu_sub_sel)
    else $error("peripheral clock not on CPU clock source");
  glitch_gap_a: assert property (
    $rose(clk_gate_off) |-> gate_cycle ##1 status_settles)
    else $error("status updated without the gated gap");
  int_stop_guard_a: assert property (
    $rose(int_stop) |-> $past(mstat || cstat))
    else $error("internal oscillator stopped while in use");
  hs_stop_guard_a: assert property (
    $rose(hs_stop) |-> $past(!mstat || cstat))
    else $error("high-speed source stopped while in use");
  sub_stop_guard_a: assert property (
    $rose(sub_stop) |-> $past(!cstat))
    else $error("subsystem oscillator stopped while in use");
  cfg_byte_only_a: assert property (
    $rose(cfg_done) |-> $past(wb_sel_i == CCS_SEL_BYTE0))
    else $error("mode configuration taken from a wide write");
endmodule

// File: ccs_osc_model.sv
`timescale 1ns/1ps
module ccs_osc_model #(
  parameter int STAB = 30
) (
  input wire logic ref_clk,
  input wire logic hs_osc_en,
  input wire logic hs_ext_en,
  input wire logic sub_osc_en,
  output logic hs_ready_pin,
  output logic sub_ready_pin
);
  int hs_cnt = 0;
  int sub_cnt = 0;
  // Disabling a source restarts its stabilization count
  always @(posedge ref_clk) begin
    hs_cnt <= hs_osc_en ? hs_cnt + int'(hs_cnt < STAB) : 0;
    sub_cnt <= sub_osc_en ? sub_cnt + int'(sub_cnt < STAB) : 0;
  end
  // External input needs no stabilization wait
  assign hs_ready_pin = hs_ext_en | (hs_cnt == STAB);
  assign sub_ready_pin = sub_osc_en & (sub_cnt == STAB);
endmodule

// File: ccs_clock_switch_tb.sv
`timescale 1ns/1ps
module ccs_clock_switch_tb;
  import ccs_pkg::*;
  localparam int FSB = 4000;
  logic ref_clk = 0, sys_rst = 1, clk_en = 1;
  logic cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 0, sel = 0;
  logic [3:0] wsel = CCS_SEL_BYTE0;
  logic [31:0] dat = 0, dat_o;
  logic ack, hs_rdy, sub_rdy, hs_osc_en, hs_ext_en, sub_osc_en, int_osc_en;
  logic main_hs_sel, cpu_sub_sel, periph_sub_sel, clk_gate_off, switch_busy;
  logic [2:0] main_div;
  logic [7:0] m_sel = 0;
  logic [2:0] m_osc = 3'h3, m_cfg = 0;
  logic m_done = 0, m_ref = 0;
  int err_count = 0, total_checks = 0;

  ccs_clock_switch #(.F_SUB_KHZ(FSB)) ccs_clock_switch_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .hs_ready_pin(hs_rdy), .sub_ready_pin(sub_rdy),
    .hs_osc_en(hs_osc_en), .hs_ext_en(hs_ext_en), .sub_osc_en(sub_osc_en),
    .int_osc_en(int_osc_en), .main_hs_sel(main_hs_sel), .main_div(main_div),
    .cpu_sub_sel(cpu_sub_sel), .periph_sub_sel(periph_sub_sel),
    .clk_gate_off(clk_gate_off), .switch_busy(switch_busy));
  ccs_osc_model ccs_osc_model_inst (
    .ref_clk(ref_clk), .hs_osc_en(hs_osc_en), .hs_ext_en(hs_ext_en),
    .sub_osc_en(sub_osc_en), .hs_ready_pin(hs_rdy),
    .sub_ready_pin(sub_rdy));

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", err_count, total_checks);
    if (err_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic int fm(input logic [7:0] s);
    return (s[4] ? CCS_F_MX_KHZ : CCS_F_IH_KHZ) >> s[2:0];
  endfunction

  // Generous bound: twice the worst ratio plus handover overhead
  function automatic int lim(input logic [7:0] o, input logic [7:0] n);
    int fa, fb, mx, mn;
    fa = o[6] ? FSB : fm(o);
    fb = n[6] ? FSB : fm(n);
    mx = fa > fb ? fa : fb;
    mn = fa > fb ? fb : fa;
    return 4 + (2 * mx + mn - 1) / mn;
  endfunction

  function automatic logic hs_ok();
    return m_cfg[1] & !m_osc[0] & (m_cfg[0] | hs_rdy);
  endfunction

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, wsel, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    chk(32'(ack), 32'h1);
  endtask

  task automatic rd(input logic [3:0] a);
    logic [31:0] q, e;
    case (a)
      CCS_OFS_CLK_SEL: e = 32'(m_sel);
      CCS_OFS_MODE_CFG: e = 32'(m_cfg);
      CCS_OFS_OSC_CTRL: e = 32'(m_osc);
      CCS_OFS_STATUS: e = 32'({m_done, m_ref, 1'b0, sub_rdy, hs_rdy});
      default: e = 32'h0;
    endcase
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q, e;
    logic [7:0] o;
    logic ok;
    int n, g;
    o = m_sel;
    ok = 1;
    if (a == CCS_OFS_CLK_SEL) begin
      if (d[4] & !o[4]) ok &= hs_ok();
      if (!d[4] & o[4]) ok &= !m_osc[2];
      if (d[6] & !o[6]) ok &= m_cfg[2] & !m_osc[1] & sub_rdy;
      if (!d[6] & o[6])
        ok &= d[4] == o[4] && (o[4] ? hs_ok() : !m_osc[2]);
      if (ok) m_sel = {d[6], d[6], d[4], d[4], 1'b0, d[2:0]};
    end else if (a == CCS_OFS_MODE_CFG) begin
      // Only the first byte-wide write after reset is taken
      if (!m_done && wsel == CCS_SEL_BYTE0) begin
        m_cfg = d[2:0];
        m_done = 1;
      end else ok = 0;
    end else if (a == CCS_OFS_OSC_CTRL) begin
      for (int i = 0; i < 3; i++) begin
        if (d[i] & !m_osc[i] & (i == 0 ? o[5] & !o[7] :
            i == 1 ? o[7] : !o[5] & !o[7])) ok = 0;
        else m_osc[i] = d[i];
      end
    end else if (a == CCS_OFS_STATUS && d[3]) m_ref = 0;
    if (!ok) m_ref = 1;
    bus(1'b1, a, 32'(d), q);
    if (a == CCS_OFS_CLK_SEL && m_sel != o) begin
      n = 0;
      g = 0;
      do begin
        @(negedge ref_clk);
        n++;
        g += int'(clk_gate_off === 1'b1);
      end while (switch_busy === 1'b1 && n < 2000);
      ok = n > 1 && n <= lim(o, m_sel) + 1;
      chk(32'(ok), 32'h1);
      chk(g, 1);
      q = 32'({cpu_sub_sel, periph_sub_sel, main_hs_sel, main_div});
      e = 32'({m_sel[6], m_sel[6], m_sel[4], m_sel[2:0]});
      chk(q, e);
    end
    if (a == CCS_OFS_OSC_CTRL) begin
      repeat (2) @(negedge ref_clk);
      q = 32'({hs_osc_en, hs_ext_en, int_osc_en, sub_osc_en});
      e = 32'({m_cfg[1] & !m_cfg[0] & !m_osc[0],
               m_cfg[1] & m_cfg[0] & !m_osc[0],
               !m_osc[2], m_cfg[2] & !m_osc[1]});
      chk(q, e);
    end
  endtask

  // Ready pins pass a synchroniser, so allow it to settle
  task automatic wait_rdy(input logic s);
    int n;
    n = 0;
    while ((s ? sub_rdy : hs_rdy) !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(s ? sub_rdy : hs_rdy), 32'h1);
    repeat (6) @(posedge ref_clk);
  endtask

  initial begin
    #500000;
    err_count++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h1d39094c));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 0;
    rd(CCS_OFS_CLK_SEL);
    rd(CCS_OFS_OSC_CTRL);
    rd(CCS_OFS_STATUS);
    rd(4'h2);
    wr(CCS_OFS_OSC_CTRL, 8'h07);
    rd(CCS_OFS_STATUS);
    wr(CCS_OFS_STATUS, 8'h08);
    wr(CCS_OFS_CLK_SEL, 8'h10);
    wr(CCS_OFS_STATUS, 8'h08);
    wr(CCS_OFS_MODE_CFG, 8'h06);
    wr(CCS_OFS_MODE_CFG, 8'h01);
    rd(CCS_OFS_MODE_CFG);
    rd(CCS_OFS_STATUS);
    wr(CCS_OFS_STATUS, 8'h08);
    wr(CCS_OFS_OSC_CTRL, 8'h02);
    wait_rdy(1'b0);
    wr(CCS_OFS_CLK_SEL, 8'h10);
    rd(CCS_OFS_CLK_SEL);
    wr(CCS_OFS_OSC_CTRL, 8'h06);
    wr(CCS_OFS_CLK_SEL, 8'h00);
    wr(CCS_OFS_OSC_CTRL, 8'h04);
    wait_rdy(1'b1);
    wr(CCS_OFS_CLK_SEL, 8'h50);
    rd(CCS_OFS_CLK_SEL);
    wr(CCS_OFS_OSC_CTRL, 8'h06);
    wr(CCS_OFS_OSC_CTRL, 8'h05);
    wr(CCS_OFS_CLK_SEL, 8'h10);
    wr(CCS_OFS_CLK_SEL, 8'h40);
    wr(CCS_OFS_OSC_CTRL, 8'h01);
    wr(CCS_OFS_CLK_SEL, 8'h40);
    wr(CCS_OFS_CLK_SEL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(CCS_OFS_CLK_SEL, 8'($urandom % 8));
    end
    rd(CCS_OFS_CLK_SEL);
    rd(CCS_OFS_STATUS);
    // Second reset: the crystal/external choice opens again
    sys_rst <= 1;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 0;
    m_sel = 0;
    m_osc = 3'h3;
    m_cfg = 0;
    m_done = 0;
    m_ref = 0;
    rd(CCS_OFS_CLK_SEL);
    wsel = 4'hf;
    wr(CCS_OFS_MODE_CFG, 8'h03);
    wsel = CCS_SEL_BYTE0;
    rd(CCS_OFS_STATUS);
    wr(CCS_OFS_STATUS, 8'h08);
    wr(CCS_OFS_MODE_CFG, 8'h03);
    wr(CCS_OFS_OSC_CTRL, 8'h02);
    wr(CCS_OFS_CLK_SEL, 8'h10);
    rd(CCS_OFS_CLK_SEL);
    complete_run();
  end
endmodule
